// >>> common/igs_pkg.sv
package igs_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_PWR      = 8'h19;
    localparam logic [ADDR_W-1:0] ADDR_LCTL     = 8'h25;
    localparam logic [ADDR_W-1:0] ADDR_RCTL     = 8'h26;
    localparam logic [ADDR_W-1:0] ADDR_DETACH   = 8'hcc;
    localparam logic [ADDR_W-1:0] ADDR_KEY      = 8'hfd;
    localparam logic [ADDR_W-1:0] ADDR_SC_CFG   = 8'he0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'he1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'he2;

    // field positions
    localparam int PWR_LEFT_BIT  = 5;
    localparam int PWR_RIGHT_BIT = 4;
    localparam int CTL_ONLY_BIT  = 4;
    localparam int CTL_SEL_LSB   = 0;
    localparam int SEL_W         = 4;
    localparam int SC_ENA_BIT    = 0;
    localparam int SC_POL_BIT    = 1;
    localparam int SC_THR_LSB    = 2;
    localparam int SC_THR_W      = 2;
    localparam int SC_STATE_BIT  = 4;
    localparam int IRQ_SC_BIT    = 0;
    localparam int IRQ_W         = 1;
    localparam int DETACH_BIT    = 6;

    // reset values and keys
    localparam logic [SEL_W-1:0]    SEL_RESET    = 4'h8;
    localparam logic [DATA_W-1:0]   KEY_OPEN     = 16'h0001;
    localparam logic [DATA_W-1:0]   WORD_ZERO    = 16'h0000;
    localparam logic [SC_THR_W-1:0] THR_RESET    = 2'h0;
    localparam logic [IRQ_W-1:0]    IRQ_ZERO     = 1'h0;

    // timing
    localparam int CLK_PERIOD_NS  = 4;
    localparam int MEAS_PERIOD_NS = 1000;
    localparam int MEAS_CYCLES    = MEAS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FILT_COUNT     = 10;

    // debounced state of the short-circuit comparator
    typedef enum logic {
        IGS_SC_OPEN  = 1'b0,
        IGS_SC_SHORT = 1'b1
    } igs_sc_state_type;
endpackage : igs_pkg

// >>> common/igs_stage_if.sv
`timescale 1ns/1ns
`default_nettype none
interface igs_stage_if;
    import igs_pkg::*;
    logic             combined_en;
    logic             stage_only_en;
    logic [SEL_W-1:0] pin_sel;
    logic             stage_pwr;
    logic             mixer_pwr;
    logic [SEL_W-1:0] pin_conn;

    modport ctrl (output combined_en, output stage_only_en, output pin_sel,
                  input stage_pwr, input mixer_pwr, input pin_conn);
    modport stage (input combined_en, input stage_only_en, input pin_sel,
                   output stage_pwr, output mixer_pwr, output pin_conn);
endinterface : igs_stage_if
`default_nettype wire

// >>> design/igs_stage_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module igs_stage_ctrl
    import igs_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    igs_stage_if.stage st
);
    // power controls: the combined enable covers stage and mixer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.mixer_pwr <= 1'b0;
            st.stage_pwr <= 1'b0;
        end else begin
            st.mixer_pwr <= st.combined_en;
            st.stage_pwr <= st.combined_en | st.stage_only_en;
        end
    end

    // pin switches follow their select bits one by one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.pin_conn <= SEL_RESET;
        end else begin
            st.pin_conn <= st.pin_sel;
        end
    end

    property p_mixer;
        @(posedge clk) disable iff (!arst_n)
        st.combined_en |=> st.mixer_pwr && st.stage_pwr;
    endproperty
    a_mixer: assert property (p_mixer) else $error("combined enable left stage off");

    property p_stage_off;
        @(posedge clk) disable iff (!arst_n)
        !st.combined_en && !st.stage_only_en |=> !st.stage_pwr && !st.mixer_pwr;
    endproperty
    a_stage_off: assert property (p_stage_off) else $error("stage powered with no enable");

    property p_only;
        @(posedge clk) disable iff (!arst_n)
        st.stage_only_en && !st.combined_en |=> st.stage_pwr && !st.mixer_pwr;
    endproperty
    a_only: assert property (p_only) else $error("stage-only enable misbehaves");

    property p_mute;
        @(posedge clk) disable iff (!arst_n)
        (st.pin_sel == '0)[*2] |=> st.pin_conn == '0;
    endproperty
    a_mute: assert property (p_mute) else $error("pin still connected with no select");

    property p_sel;
        @(posedge clk) disable iff (!arst_n)
        1'b1 |=> st.pin_conn == $past(st.pin_sel);
    endproperty
    a_sel: assert property (p_sel) else $error("pin connection differs from select");
endmodule : igs_stage_ctrl
`default_nettype wire

// >>> design/igs_sc_filter.sv
`timescale 1ns/1ns
`default_nettype none
module igs_sc_filter
    import igs_pkg::*;
#(
    parameter int COUNT = FILT_COUNT
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic enable,
    input  wire logic tick,
    input  wire logic level,
    output var  logic press,
    output var  logic release_ev,
    output var  logic shorted
);
    localparam int CNT_W = $clog2(COUNT + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(COUNT - 1);

    igs_sc_state_type state_q;
    logic [CNT_W-1:0] cnt_q;

    // a new level must hold for COUNT measurements in a row before it counts;
    // one agreeing sample restarts the run, which rejects short current spikes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q    <= IGS_SC_OPEN;
            cnt_q      <= '0;
            press      <= 1'b0;
            release_ev <= 1'b0;
        end else begin
            press      <= 1'b0;
            release_ev <= 1'b0;
            if (!enable) begin
                state_q <= IGS_SC_OPEN; // silent: disabling raises no event
                cnt_q   <= '0;
            end else if (tick) begin
                if (level == state_q) begin
                    cnt_q <= '0;
                end else if (cnt_q == CNT_LAST) begin
                    cnt_q <= '0;
                    unique case (state_q)
                        IGS_SC_OPEN: begin
                            state_q <= IGS_SC_SHORT;
                            press   <= 1'b1;
                        end
                        IGS_SC_SHORT: begin
                            state_q    <= IGS_SC_OPEN;
                            release_ev <= 1'b1;
                        end
                    endcase
                end else begin
                    cnt_q <= cnt_q + CNT_W'(1);
                end
            end
        end
    end

    assign shorted = (state_q == IGS_SC_SHORT);

    property p_filt_cnt;
        @(posedge clk) disable iff (!arst_n)
        press || release_ev |-> $past(cnt_q) == CNT_LAST && $past(tick);
    endproperty
    a_filt_cnt: assert property (p_filt_cnt) else $error("event before full run");

    property p_filt_lvl;
        @(posedge clk) disable iff (!arst_n)
        press |-> $past(level) && !$past(shorted);
    endproperty
    a_filt_lvl: assert property (p_filt_lvl) else $error("press without short level");
endmodule : igs_sc_filter
`default_nettype wire

// >>> design/igs_top.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - left combined bit powers left stage, mixer
// - right combined bit powers right stage, mixer
// - left stage on if either enable set
// - right stage on if either enable set
// - four left bits connect left pins
// - four right bits connect right pins
// - no selects disconnects all pins
// - short event after ten consecutive measurements
// - polarity picks press or release event
module igs_top
    import igs_pkg::*;
#(
    parameter int MEAS_CNT = MEAS_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output var  logic [DATA_W-1:0]   rdata,
    input  wire logic                short_circuit_raw,
    output var  logic                irq,
    output wire logic                left_stage_power,
    output wire logic                left_mixer_power,
    output wire logic [SEL_W-1:0]    left_pin_connect,
    output wire logic                right_stage_power,
    output wire logic                right_mixer_power,
    output wire logic [SEL_W-1:0]    right_pin_connect,
    output var  logic                pin4_reference_detach,
    output var  logic [SC_THR_W-1:0] short_circuit_threshold
);
    localparam int DIV_W = $clog2(MEAS_CNT + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MEAS_CNT - 1);

    // software-visible state
    logic                left_stage_mixer_enable_q;
    logic                right_stage_mixer_enable_q;
    logic                left_stage_only_enable_q;
    logic                right_stage_only_enable_q;
    logic [SEL_W-1:0]    left_sel_q;
    logic [SEL_W-1:0]    right_sel_q;
    logic [DATA_W-1:0]   key_q;
    logic [DATA_W-1:0]   detach_q;
    logic                sc_enable_q;
    logic                short_circuit_irq_polarity_q;
    logic [SC_THR_W-1:0] thr_q;
    logic [IRQ_W-1:0]    status_q;
    logic [IRQ_W-1:0]    status_d;
    logic [IRQ_W-1:0]    mask_q;
    logic [IRQ_W-1:0]    mask_d;
    logic [IRQ_W-1:0]    clr_vec;
    logic [IRQ_W-1:0]    set_vec;

    // detection path
    logic             sync1_q;
    logic             sync2_q;
    logic [DIV_W-1:0] div_q;
    logic             tick_q;
    logic             sc_press;
    logic             sc_release;
    logic             sc_shorted;

    igs_stage_if left_if ();
    igs_stage_if right_if ();

    // true when a strobe targets the given offset
    function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] target);
        hit = strobe && (a == target);
    endfunction : hit

    // enable and selection registers; only documented bits are stored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            left_stage_mixer_enable_q  <= 1'b0;
            right_stage_mixer_enable_q <= 1'b0;
            left_stage_only_enable_q   <= 1'b0;
            right_stage_only_enable_q  <= 1'b0;
            left_sel_q                 <= SEL_RESET;
            right_sel_q                <= SEL_RESET;
        end else begin
            if (hit(wr, addr, ADDR_PWR)) begin
                left_stage_mixer_enable_q  <= wdata[PWR_LEFT_BIT];
                right_stage_mixer_enable_q <= wdata[PWR_RIGHT_BIT];
            end
            if (hit(wr, addr, ADDR_LCTL)) begin
                left_stage_only_enable_q <= wdata[CTL_ONLY_BIT];
                left_sel_q               <= wdata[CTL_SEL_LSB +: SEL_W];
            end
            if (hit(wr, addr, ADDR_RCTL)) begin
                right_stage_only_enable_q <= wdata[CTL_ONLY_BIT];
                right_sel_q               <= wdata[CTL_SEL_LSB +: SEL_W];
            end
        end
    end

    // the detach word only takes a write while the access key is open
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            key_q                 <= WORD_ZERO;
            detach_q              <= WORD_ZERO;
            pin4_reference_detach <= 1'b0;
        end else begin
            if (hit(wr, addr, ADDR_KEY)) begin
                key_q <= wdata;
            end
            if (hit(wr, addr, ADDR_DETACH) && key_q == KEY_OPEN) begin
                detach_q              <= wdata;
                pin4_reference_detach <= wdata[DETACH_BIT];
            end
        end
    end

    // short-circuit detection configuration
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sc_enable_q                  <= 1'b0;
            short_circuit_irq_polarity_q <= 1'b0;
            thr_q                        <= THR_RESET;
            short_circuit_threshold      <= THR_RESET;
            mask_q                       <= IRQ_ZERO;
        end else begin
            if (hit(wr, addr, ADDR_SC_CFG)) begin
                sc_enable_q                  <= wdata[SC_ENA_BIT];
                short_circuit_irq_polarity_q <= wdata[SC_POL_BIT];
                thr_q                        <= wdata[SC_THR_LSB +: SC_THR_W];
                short_circuit_threshold      <= wdata[SC_THR_LSB +: SC_THR_W];
            end
            mask_q <= mask_d;
        end
    end

    assign mask_d = hit(wr, addr, ADDR_IRQ_MASK) ? wdata[IRQ_W-1:0] : mask_q;

    // hand the settings to the two stage controllers
    assign left_if.combined_en    = left_stage_mixer_enable_q;
    assign left_if.stage_only_en  = left_stage_only_enable_q;
    assign left_if.pin_sel        = left_sel_q;
    assign right_if.combined_en   = right_stage_mixer_enable_q;
    assign right_if.stage_only_en = right_stage_only_enable_q;
    assign right_if.pin_sel       = right_sel_q;

    igs_stage_ctrl u_left (
        .clk    (clk),
        .arst_n (arst_n),
        .st     (left_if.stage)
    );

    igs_stage_ctrl u_right (
        .clk    (clk),
        .arst_n (arst_n),
        .st     (right_if.stage)
    );

    assign left_stage_power  = left_if.stage_pwr;
    assign left_mixer_power  = left_if.mixer_pwr;
    assign left_pin_connect  = left_if.pin_conn;
    assign right_stage_power = right_if.stage_pwr;
    assign right_mixer_power = right_if.mixer_pwr;
    assign right_pin_connect = right_if.pin_conn;

    // comparator output is asynchronous to clk: two flops before use
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= short_circuit_raw;
            sync2_q <= sync1_q;
        end
    end

    // measurement rate divider; held idle while detection is off to save power
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (!sc_enable_q || div_q == DIV_LAST) begin
                div_q  <= '0;
                tick_q <= sc_enable_q;
            end else begin
                div_q <= div_q + DIV_W'(1);
            end
        end
    end

    igs_sc_filter #(
        .COUNT (FILT_COUNT)
    ) u_filter (
        .clk        (clk),
        .arst_n     (arst_n),
        .enable     (sc_enable_q),
        .tick       (tick_q),
        .level      (sync2_q),
        .press      (sc_press),
        .release_ev (sc_release),
        .shorted    (sc_shorted)
    );

    // polarity chooses which edge of the hook switch is reported
    always_comb begin
        set_vec = IRQ_ZERO;
        set_vec[IRQ_SC_BIT] = short_circuit_irq_polarity_q ? sc_release : sc_press;
        clr_vec = hit(wr, addr, ADDR_IRQ_STAT) ? wdata[IRQ_W-1:0] : IRQ_ZERO;
        status_d = (status_q & ~clr_vec) | set_vec; // set beats a same-cycle clear
    end

    // sticky status and level interrupt, both registered
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= IRQ_ZERO;
            irq      <= 1'b0;
        end else begin
            status_q <= status_d;
            irq      <= |(status_d & mask_d);
        end
    end

    // read port: data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= WORD_ZERO;
        end else begin
            rdata <= WORD_ZERO;
            if (rd) begin
                unique case (addr)
                    ADDR_PWR: begin
                        rdata[PWR_LEFT_BIT]  <= left_stage_mixer_enable_q;
                        rdata[PWR_RIGHT_BIT] <= right_stage_mixer_enable_q;
                    end
                    ADDR_LCTL: begin
                        rdata[CTL_ONLY_BIT]            <= left_stage_only_enable_q;
                        rdata[CTL_SEL_LSB +: SEL_W]    <= left_sel_q;
                    end
                    ADDR_RCTL: begin
                        rdata[CTL_ONLY_BIT]            <= right_stage_only_enable_q;
                        rdata[CTL_SEL_LSB +: SEL_W]    <= right_sel_q;
                    end
                    ADDR_KEY:    rdata <= key_q;
                    ADDR_DETACH: rdata <= detach_q;
                    ADDR_SC_CFG: begin
                        rdata[SC_ENA_BIT]               <= sc_enable_q;
                        rdata[SC_POL_BIT]               <= short_circuit_irq_polarity_q;
                        rdata[SC_THR_LSB +: SC_THR_W]   <= thr_q;
                        rdata[SC_STATE_BIT]             <= sc_shorted;
                    end
                    ADDR_IRQ_STAT: rdata[IRQ_W-1:0] <= status_q;
                    ADDR_IRQ_MASK: rdata[IRQ_W-1:0] <= mask_q;
                    default:       rdata <= WORD_ZERO;
                endcase
            end
        end
    end

    property p_press_irq;
        @(posedge clk) disable iff (!arst_n)
        sc_press && !short_circuit_irq_polarity_q |=> status_q[IRQ_SC_BIT];
    endproperty
    a_press_irq: assert property (p_press_irq) else $error("press did not set status");

    property p_release_irq;
        @(posedge clk) disable iff (!arst_n)
        $rose(status_q[IRQ_SC_BIT]) |->
            $past(short_circuit_irq_polarity_q) ? $past(sc_release) : $past(sc_press);
    endproperty
    a_release_irq: assert property (p_release_irq) else $error("status set by wrong edge");

    property p_pwr_read;
        @(posedge clk) disable iff (!arst_n)
        rd && addr == ADDR_PWR |=> rdata[PWR_RIGHT_BIT-1:0] == '0
            && rdata[DATA_W-1:PWR_LEFT_BIT+1] == '0;
    endproperty
    a_pwr_read: assert property (p_pwr_read) else $error("undescribed bit reads one");

    property p_pwr_write;
        @(posedge clk) disable iff (!arst_n)
        wr && addr == ADDR_PWR ##2 rd && addr == ADDR_PWR && !$past(wr, 1)
            |=> rdata[PWR_LEFT_BIT] == $past(wdata[PWR_LEFT_BIT], 3);
    endproperty
    a_pwr_write: assert property (p_pwr_write) else $error("left enable not stored");

    property p_rd_idle;
        @(posedge clk) disable iff (!arst_n)
        !rd |=> rdata == WORD_ZERO;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

    property p_irq_level;
        @(posedge clk) disable iff (!arst_n)
        1'b1 |-> irq == |(status_q & mask_q);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq differs from status");

    // the detach word must not move while the access key is closed
    property p_detach_lock;
        @(posedge clk) disable iff (!arst_n)
        key_q != KEY_OPEN |=> $stable(detach_q);
    endproperty
    a_detach_lock: assert property (p_detach_lock) else $error("detach written while locked");
endmodule : igs_top
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import igs_pkg::*;
;
    // short measurement period keeps the debounce runs brief
    localparam int MEAS = 4;

    logic                clk;
    logic                arst_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic                wr;
    logic                rd;
    logic [DATA_W-1:0]   rdata;
    logic                short_circuit_raw;
    logic                irq;
    logic                left_stage_power;
    logic                left_mixer_power;
    logic [SEL_W-1:0]    left_pin_connect;
    logic                right_stage_power;
    logic                right_mixer_power;
    logic [SEL_W-1:0]    right_pin_connect;
    logic                pin4_reference_detach;
    logic [SC_THR_W-1:0] short_circuit_threshold;
    logic [DATA_W-1:0]   outs;
    int                  err_count = 0;
    int                  n_tests = 0;
    int                  cnt;

    igs_top #(.MEAS_CNT(MEAS)) u_dut (
        .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .short_circuit_raw(short_circuit_raw), .irq(irq),
        .left_stage_power(left_stage_power), .left_mixer_power(left_mixer_power),
        .left_pin_connect(left_pin_connect), .right_stage_power(right_stage_power),
        .right_mixer_power(right_mixer_power), .right_pin_connect(right_pin_connect),
        .pin4_reference_detach(pin4_reference_detach),
        .short_circuit_threshold(short_circuit_threshold)
    );

    // all stage outputs packed into one word so one compare covers both sides
    assign outs = {4'h0, left_stage_power, left_mixer_power, left_pin_connect,
                   right_stage_power, right_mixer_power, right_pin_connect};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [DATA_W-1:0] o(input logic ls, input logic lm,
                                            input logic [3:0] lp, input logic rs,
                                            input logic rm, input logic [3:0] rp);
        return {4'h0, ls, lm, lp, rs, rm, rp};
    endfunction : o

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe edge
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd_chk

    // stage outputs follow a write two edges later
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    initial begin
        addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0; short_circuit_raw = 1'b0;
        arst_n = 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(outs, o(1'b0, 1'b0, 4'h8, 1'b0, 1'b0, 4'h8));
        rd_chk(ADDR_PWR, 16'h0000);
        rd_chk(ADDR_LCTL, 16'h0008);
        rd_chk(ADDR_RCTL, 16'h0008);
        rd_chk(ADDR_DETACH, 16'h0000);
        rd_chk(8'h10, 16'h0000);
        // host has reference and bias current up before any stage enable
        // enables: combined bits, stage-only bits and their OR
        wr_reg(ADDR_PWR, 16'hffff);
        rd_chk(ADDR_PWR, 16'h0030);
        settle();
        chk(outs, o(1'b1, 1'b1, 4'h8, 1'b1, 1'b1, 4'h8));
        wr_reg(ADDR_PWR, 16'h0020);
        settle();
        chk(outs, o(1'b1, 1'b1, 4'h8, 1'b0, 1'b0, 4'h8));
        wr_reg(ADDR_PWR, 16'h0010);
        settle();
        chk(outs, o(1'b0, 1'b0, 4'h8, 1'b1, 1'b1, 4'h8));
        wr_reg(ADDR_PWR, 16'h0000);
        // left pins one and four are never selected together
        wr_reg(ADDR_LCTL, 16'hfffe);
        rd_chk(ADDR_LCTL, 16'h001e);
        wr_reg(ADDR_RCTL, 16'h0010);
        settle();
        chk(outs, o(1'b1, 1'b0, 4'he, 1'b1, 1'b0, 4'h0));
        wr_reg(ADDR_PWR, 16'h0030);
        settle();
        chk(outs, o(1'b1, 1'b1, 4'he, 1'b1, 1'b1, 4'h0));
        // each select bit alone, walking opposite ways on the two sides
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_LCTL, DATA_W'(1 << i));
            wr_reg(ADDR_RCTL, DATA_W'(8 >> i));
            settle();
            chk(outs, o(1'b1, 1'b1, 4'(1 << i), 1'b1, 1'b1, 4'(8 >> i)));
        end
        wr_reg(ADDR_LCTL, 16'h0000);
        wr_reg(ADDR_RCTL, 16'h0000);
        settle();
        chk(outs, o(1'b1, 1'b1, 4'h0, 1'b1, 1'b1, 4'h0));
        wr_reg(ADDR_PWR, 16'h0000);
        settle();
        chk(outs, o(1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 4'h0));
        // detach word is locked until the key is written
        wr_reg(ADDR_DETACH, 16'h0040);
        rd_chk(ADDR_DETACH, 16'h0000);
        wr_reg(ADDR_KEY, 16'h0001);
        wr_reg(ADDR_DETACH, 16'h0040);
        wr_reg(ADDR_KEY, 16'h0000);
        settle();
        chk(16'(pin4_reference_detach), 16'h0001);
        rd_chk(ADDR_DETACH, 16'h0040);
        // host keeps bias level 00, highpass off and 0dB gain while measuring
        // short detection: a short burst must be filtered out
        wr_reg(ADDR_IRQ_MASK, 16'h0001);
        wr_reg(ADDR_LCTL, 16'h0008);
        wr_reg(ADDR_SC_CFG, 16'h000d);
        settle();
        chk(16'(short_circuit_threshold), 16'h0003);
        short_circuit_raw <= 1'b1;
        idle(5 * MEAS);
        short_circuit_raw <= 1'b0;
        idle(20 * MEAS);
        rd_chk(ADDR_IRQ_STAT, 16'h0000);
        // press with polarity 0: two sync flops, ten ticks, one status edge
        @(posedge clk);
        short_circuit_raw <= 1'b1;
        cnt = 0;
        while (irq !== 1'b1 && cnt < 100) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        chk(16'(cnt >= (FILT_COUNT - 1) * MEAS + 4
                && cnt <= FILT_COUNT * MEAS + 3), 16'h0001);
        rd_chk(ADDR_IRQ_STAT, 16'h0001);
        rd_chk(ADDR_SC_CFG, 16'h001d);
        // press seen: swap the left stage from pin four to pin one
        wr_reg(ADDR_LCTL, 16'h0001);
        settle();
        chk(outs, o(1'b0, 1'b0, 4'h1, 1'b0, 1'b0, 4'h0));
        wr_reg(ADDR_IRQ_STAT, 16'h0001);
        settle();
        chk(16'(irq), 16'h0000);
        short_circuit_raw <= 1'b0;
        idle(20 * MEAS);
        rd_chk(ADDR_IRQ_STAT, 16'h0000);
        // polarity 1: press is silent, release sets the masked status
        wr_reg(ADDR_IRQ_MASK, 16'h0000);
        wr_reg(ADDR_SC_CFG, 16'h000f);
        short_circuit_raw <= 1'b1;
        idle(20 * MEAS);
        rd_chk(ADDR_IRQ_STAT, 16'h0000);
        short_circuit_raw <= 1'b0;
        idle(20 * MEAS);
        rd_chk(ADDR_IRQ_STAT, 16'h0001);
        chk(16'(irq), 16'h0000);
        wr_reg(ADDR_IRQ_MASK, 16'h0001);
        settle();
        chk(16'(irq), 16'h0001);
        wr_reg(ADDR_IRQ_STAT, 16'h0001);
        settle();
        chk(16'(irq), 16'h0000);
        end_of_test();
    end

    // the whole sequence needs about five hundred cycles
    initial begin
        #(20000 * 4);
        err_count++;
        $display("BAD t=%0t watchdog expired", $time);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
